// >>> include/pfcr_pkg.sv
// Package: constants, field layout and state type of the potentiometer feature/control registers
package pfcr_pkg;

	// Feature byte field positions
	localparam int TAPER_BIT      = 0;
	localparam int VOLATILE_BIT   = 1;
	localparam int COUNT_LSB      = 2;
	localparam int POSITIONS_LSB  = 4;
	localparam int RESIST_LSB     = 6;

	// Feature byte field codes of this part
	localparam logic       TAPER_LINEAR      = 1'h1;
	localparam logic       TAPER_LOG         = 1'h0;
	localparam logic       WIPER_VOLATILE    = 1'h1;
	localparam logic       WIPER_NONVOLATILE = 1'h0;
	localparam logic [1:0] COUNT_ONE         = 2'h0;
	localparam logic [1:0] POSITIONS_256     = 2'h3;
	localparam logic [1:0] RESIST_100K       = 2'h3;
	localparam logic [7:0] FEATURE_VALUE     = 8'hF3;

	// Control byte field positions
	localparam int WSEL_LSB       = 0;
	localparam int WSEL_CMPL_LSB  = 2;
	localparam int PUMP_BIT       = 6;

	// Control byte reset and accepted values
	localparam logic [7:0] CTRL_RESET        = 8'h0C;
	localparam logic [7:0] CTRL_PUMP_OFF     = 8'h0C;
	localparam logic [7:0] CTRL_PUMP_ON      = 8'h4C;

	// Function command and handshake codes
	localparam logic [7:0] CMD_READ_REGS     = 8'hAA;
	localparam logic [7:0] CMD_WRITE_CTRL    = 8'h55;
	localparam logic [7:0] RELEASE_CODE      = 8'h96;
	localparam logic [7:0] INVALID_ECHO      = 8'hFF;
	localparam logic [15:0] ALL_ONES         = 16'hFFFF;
	localparam logic [15:0] ALL_ZEROS        = 16'h0000;

	// Function sequencer states
	typedef enum logic [2:0] {
		S_IDLE,
		S_CMD,
		S_READ,
		S_WR_VALUE,
		S_WR_RELEASE,
		S_DONE,
		S_IGNORE
	} pfcr_state_t;

	// Only two control values are accepted
	function automatic logic ctrl_is_valid(input logic [7:0] value);
		ctrl_is_valid = (value == CTRL_PUMP_OFF) || (value == CTRL_PUMP_ON);
	endfunction : ctrl_is_valid

endpackage : pfcr_pkg

// >>> hw/pfcr_rx_byte.sv
// Byte assembler: gathers written bit slots LSB first into bytes
`timescale 1ns/100ps
module pfcr_rx_byte #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Bit side
	input  wire logic             clear,
	input  wire logic             bitValid,
	input  wire logic             bitIn,
	// Byte side
	output logic                  byteDone,
	output logic [WIDTH-1:0]      byteOut
);

	localparam int CW = $clog2(WIDTH);
	localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

	logic [WIDTH-1:0] shift_reg;
	logic [CW-1:0]    count_reg;
	logic             done_reg;

	// First bit lands at the top and walks down, so the first bit ends as bit 0
	always_ff @(posedge clk_sys) begin
		if (!rst_n || clear) begin
			shift_reg <= '0;
			count_reg <= '0;
			done_reg  <= 1'b0;
		end else begin
			done_reg <= bitValid && (count_reg == LAST);
			if (bitValid) begin
				shift_reg <= {bitIn, shift_reg[WIDTH-1:1]};
				count_reg <= count_reg + CW'(1);
			end
		end
	end

	assign byteDone = done_reg;
	assign byteOut  = shift_reg;

endmodule : pfcr_rx_byte

// >>> hw/pfcr_tx_shift.sv
// Serialiser: presents loaded bits LSB first, then a fill level, one per read slot
`timescale 1ns/100ps
module pfcr_tx_shift #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Load side
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] loadValue,
	input  wire logic             loadFill,
	// Slot side
	input  wire logic             shiftEn,
	output logic                  serialOut
);

	logic [WIDTH-1:0] shift_reg;
	logic             fill_reg;

	// Idle level is one, which is what a released line reads as
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			shift_reg <= '1;
			fill_reg  <= 1'b1;
		end else if (load) begin
			shift_reg <= loadValue;
			fill_reg  <= loadFill;
		end else if (shiftEn) begin
			shift_reg <= {fill_reg, shift_reg[WIDTH-1:1]};
		end
	end

	assign serialOut = shift_reg[0];

endmodule : pfcr_tx_shift

// >>> hw/pfcr_regs.sv
// Feature and control registers with their read and write function sequencer
//
// Notes on behaviour
// - Feature bit 0 gives taper: zero logarithmic, one linear.
// - Feature bit 1 gives volatility: zero kept unpowered, one lost at power-down.
// - Feature bits 3:2 give element count, codes 0 to 3 mean one to four.
// - Feature bits 5:4 give positions: 32, 64, 128 or 256.
// - Feature bits 7:6 give resistance: 5k, 10k, 50k or 100k ohm.
// - Register read returns the constant feature byte F3h.
// - Control bits 1:0 select which element's wiper later commands address.
// - Control bits 3:2 hold the ones complement of the wiper select.
// - Control bit 6 switches the charge pump, one meaning on.
// - After reset control holds pump off, select 00b, complement 11b.
// - Only control values 0Ch and 4Ch are accepted.
// - Any other control value leaves the control byte unchanged.
// - Every byte travels least significant bit first.
// - Read command returns feature byte, then control byte, then zeros.
// - Write echoes value or FFh; an accepted value commits on 96h then zeros, else ones.
`timescale 1ns/100ps
module pfcr_regs (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Function layer events from the bit-slot engine
	input  wire logic       busReset,
	input  wire logic       cmdStart,
	// Bit slots
	input  wire logic       wrSlot,
	input  wire logic       wrBit,
	input  wire logic       rdSlot,
	output logic            rdBit,
	// Register view
	output logic [7:0]      featureByte,
	output logic [7:0]      controlByte,
	output logic [1:0]      wiperSelect,
	// Analogue control
	output logic            pumpEnable
);

	pfcr_pkg::pfcr_state_t state_reg;
	pfcr_pkg::pfcr_state_t state_next;

	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] pend_reg;
	logic [7:0] pend_next;
	logic       pendOk_reg;
	logic       pendOk_next;

	logic       rxDone;
	logic [7:0] rxByte;
	logic       rxClear;
	logic       rxTake;
	logic       txLoad;
	logic [15:0] txValue;
	logic       txFill;
	logic       txShift;

	// Decoded events
	logic readCmd;
	logic cmdDone;
	logic valueDone;
	logic releaseDone;
	logic rxValid;
	logic commit;
	logic [7:0] echoByte;

	// Read slots since the last load, only the fill check reads it
	logic [4:0] rdCount_reg;
	logic [4:0] rdCount_next;

	// Feature byte built from its fields, no write path reaches it
	assign featureByte = {pfcr_pkg::RESIST_100K,
	                      pfcr_pkg::POSITIONS_256,
	                      pfcr_pkg::COUNT_ONE,
	                      pfcr_pkg::WIPER_VOLATILE,
	                      pfcr_pkg::TAPER_LINEAR};

	// Control view is the stored byte itself
	assign controlByte = ctrl_reg;
	assign wiperSelect = ctrl_reg[pfcr_pkg::WSEL_LSB +: 2];
	assign pumpEnable  = ctrl_reg[pfcr_pkg::PUMP_BIT];

	// Byte completions per phase
	assign cmdDone     = rxDone && (state_reg == pfcr_pkg::S_CMD);
	assign valueDone   = rxDone && (state_reg == pfcr_pkg::S_WR_VALUE);
	assign releaseDone = rxDone && (state_reg == pfcr_pkg::S_WR_RELEASE);
	assign readCmd     = (rxByte == pfcr_pkg::CMD_READ_REGS);
	assign rxValid     = pfcr_pkg::ctrl_is_valid(rxByte);
	assign commit      = releaseDone && pendOk_reg
	                     && (rxByte == pfcr_pkg::RELEASE_CODE);
	assign echoByte    = rxValid ? rxByte : pfcr_pkg::INVALID_ECHO;

	// Write slots only matter while a byte is expected from the master
	assign rxTake  = wrSlot && ((state_reg == pfcr_pkg::S_CMD)
	                 || (state_reg == pfcr_pkg::S_WR_VALUE)
	                 || (state_reg == pfcr_pkg::S_WR_RELEASE));
	assign rxClear = busReset || cmdStart;
	assign txShift = rdSlot;

	// Serialiser loads: idle ones, register pair, echo, completion level
	assign txLoad  = rxClear || cmdDone || valueDone || releaseDone;
	assign txValue = busReset || cmdStart ? pfcr_pkg::ALL_ONES
	               : (cmdDone && readCmd)
	                 ? {ctrl_reg, featureByte}
	               : valueDone ? {pfcr_pkg::INVALID_ECHO, echoByte}
	               : commit ? pfcr_pkg::ALL_ZEROS
	               : pfcr_pkg::ALL_ONES;
	// Register pair and commit run out into zeros; echo, refusal and idle into ones
	assign txFill  = !((cmdDone && readCmd) || commit);

	// Bytes in, LSB first
	pfcr_rx_byte #(
		.WIDTH     (8)
	) u_rx (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.clear     (rxClear),
		.bitValid  (rxTake),
		.bitIn     (wrBit),
		.byteDone  (rxDone),
		.byteOut   (rxByte)
	);

	// Bits out, LSB first
	pfcr_tx_shift #(
		.WIDTH     (16)
	) u_tx (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.load      (txLoad),
		.loadValue (txValue),
		.loadFill  (txFill),
		.shiftEn   (txShift),
		.serialOut (rdBit)
	);

	// Sequencer next state; a bus reset ends any function at once
	always_comb begin
		state_next  = state_reg;
		ctrl_next   = ctrl_reg;
		pend_next   = pend_reg;
		pendOk_next = pendOk_reg;
		if (busReset) begin
			state_next = pfcr_pkg::S_IDLE;
		end else if (cmdStart) begin
			state_next = pfcr_pkg::S_CMD;
		end else begin
			unique case (state_reg)
				pfcr_pkg::S_IDLE: begin
					state_next = pfcr_pkg::S_IDLE;
				end
				pfcr_pkg::S_CMD: begin
					if (rxDone) begin
						if (readCmd)
							state_next = pfcr_pkg::S_READ;
						else if (rxByte == pfcr_pkg::CMD_WRITE_CTRL)
							state_next = pfcr_pkg::S_WR_VALUE;
						else
							state_next = pfcr_pkg::S_IGNORE;
					end
				end
				pfcr_pkg::S_READ: begin
					state_next = pfcr_pkg::S_READ;
				end
				pfcr_pkg::S_WR_VALUE: begin
					// Hold the candidate until the release code arrives
					if (rxDone) begin
						pend_next   = rxByte;
						pendOk_next = rxValid;
						state_next  = pfcr_pkg::S_WR_RELEASE;
					end
				end
				pfcr_pkg::S_WR_RELEASE: begin
					if (rxDone) begin
						if (commit)
							ctrl_next = pend_reg;
						state_next = pfcr_pkg::S_DONE;
					end
				end
				pfcr_pkg::S_DONE: begin
					state_next = pfcr_pkg::S_DONE;
				end
				pfcr_pkg::S_IGNORE: begin
					state_next = pfcr_pkg::S_IGNORE;
				end
				// The unused eighth code of the state falls back to idle
				default: begin
					state_next = pfcr_pkg::S_IDLE;
				end
			endcase
		end
	end

	// State registers; control resets to pump off, wiper select 00b
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg  <= pfcr_pkg::S_IDLE;
			ctrl_reg   <= pfcr_pkg::CTRL_RESET;
			pend_reg   <= pfcr_pkg::CTRL_RESET;
			pendOk_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			ctrl_reg   <= ctrl_next;
			pend_reg   <= pend_next;
			pendOk_reg <= pendOk_next;
		end
	end

	// Saturates, so a long run of read slots cannot wrap back below the limit
	localparam logic [4:0] READ_SLOTS = 5'h10;
	assign rdCount_next = (rdSlot && (rdCount_reg != 5'h1F))
	                      ? rdCount_reg + 5'h01 : rdCount_reg;

	// A load restarts the count, as it restarts the serialiser
	always_ff @(posedge clk_sys) begin
		if (!rst_n || txLoad) begin
			rdCount_reg <= 5'h00;
		end else begin
			rdCount_reg <= rdCount_next;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence seq_read_cmd;
		cmdDone && !busReset && !cmdStart && readCmd;
	endsequence

	sequence seq_bad_value;
		valueDone && !busReset && !cmdStart && !rxValid;
	endsequence

	sequence seq_good_value;
		valueDone && !busReset && !cmdStart && rxValid;
	endsequence

	sequence seq_commit;
		commit && !busReset && !cmdStart;
	endsequence

	sequence seq_rejected_release;
		releaseDone && !commit && !busReset && !cmdStart;
	endsequence

	a_feature_value: assert property (featureByte == pfcr_pkg::FEATURE_VALUE)
		else $error("feature byte differs from F3h");

	a_ctrl_legal: assert property (pfcr_pkg::ctrl_is_valid(ctrl_reg))
		else $error("control register holds an unaccepted value");

	a_wsel_complement: assert property (ctrl_reg[3:2] == ~ctrl_reg[1:0])
		else $error("wiper select complement mismatch");

	// Reset itself is what is watched here, so this check is never disabled
	a_ctrl_after_reset: assert property (
		@(posedge clk_sys) disable iff (1'b0) !rst_n |=> ctrl_reg == pfcr_pkg::CTRL_RESET)
		else $error("control byte not at reset value after reset");

	a_ctrl_commit_only: assert property (
		!$stable(ctrl_reg) |-> $past(commit))
		else $error("control byte changed without a committed release");

	a_read_order: assert property (
		seq_read_cmd |=> rdBit == pfcr_pkg::FEATURE_VALUE[0] && state_reg == pfcr_pkg::S_READ)
		else $error("read command did not present feature bit 0");

	a_echo_invalid: assert property (
		seq_bad_value |=> rdBit && !pendOk_reg)
		else $error("invalid control value not echoed as ones");

	a_release_zero: assert property (
		seq_commit |=> !rdBit && pumpEnable == pend_reg[pfcr_pkg::PUMP_BIT])
		else $error("commit did not land or did not answer zeros");

	a_release_bad: assert property (
		seq_rejected_release |=> rdBit && $stable(ctrl_reg))
		else $error("rejected release changed state or answered zeros");

	// Accepted value comes back bit 0 first and stays pending
	a_echo_valid: assert property (
		seq_good_value |=> rdBit == pend_reg[0] && pendOk_reg)
		else $error("accepted control value not echoed from bit 0");

	// Past the feature and control bytes only zeros may follow
	a_read_fill: assert property (
		(state_reg == pfcr_pkg::S_READ) && (rdCount_reg >= READ_SLOTS) |-> !rdBit)
		else $error("register read did not run out into zeros");

	// Unknown commands leave the line released
	a_ignore_ones: assert property (
		(state_reg == pfcr_pkg::S_IGNORE) |-> rdBit)
		else $error("ignored command did not answer ones");

	// Bus reset ends any function and releases the line
	a_bus_reset_idle: assert property (
		busReset |=> (state_reg == pfcr_pkg::S_IDLE) && rdBit)
		else $error("bus reset did not end the function");

endmodule : pfcr_regs

// >>> verification/pfcr_master_model.sv
// Bus master model: drives the function-layer slot pulses toward the register block
`timescale 1ns/100ps
module pfcr_master_model (
	// Clock
	input  wire logic clk_sys,
	// Slot pulses toward the device
	output logic      busReset,
	output logic      cmdStart,
	output logic      wrSlot,
	output logic      wrBit,
	output logic      rdSlot,
	// Bit presented by the device
	input  wire logic rdBit
);
	// Quiet lines from time zero
	initial begin
		busReset = 1'h0;
		cmdStart = 1'h0;
		wrSlot   = 1'h0;
		wrBit    = 1'h1;
		rdSlot   = 1'h0;
	end

	// One-cycle strobe: bus reset or start of a function command
	task automatic pulse_cmd(input logic isReset);
		@(posedge clk_sys);
		busReset <= isReset;
		cmdStart <= ~isReset;
		@(posedge clk_sys);
		busReset <= 1'h0;
		cmdStart <= 1'h0;
		repeat (2) @(posedge clk_sys);
	endtask : pulse_cmd

	// Whole byte only; caller keeps reserved bits zero unless testing refusal
	task automatic write_byte(input logic [7:0] value);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			wrSlot <= 1'h1;
			wrBit  <= value[i];
			@(posedge clk_sys);
			wrSlot <= 1'h0;
			wrBit  <= ~value[i]; // Inverse so a stale level never looks valid
		end
		// Three quiet cycles; the device absorbs the byte within the first
		repeat (3) @(posedge clk_sys);
	endtask : write_byte

	// Sample mid-cycle, then consume the bit with a slot pulse
	task automatic read_byte(output logic [7:0] value);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_sys);
			value[i] = rdBit;
			@(posedge clk_sys);
			rdSlot <= 1'h1;
			@(posedge clk_sys);
			rdSlot <= 1'h0;
		end
	endtask : read_byte
endmodule : pfcr_master_model

// >>> verification/pfcr_regs_test.sv
// Self-checking testbench of the feature and control register block
`timescale 1ns/100ps
module pfcr_regs_test;
	// Clock and reset
	logic       clk_sys;
	logic       rst_n;
	// Slot pulses and device outputs, driven only through instance ports
	wire logic       busReset;
	wire logic       cmdStart;
	wire logic       wrSlot;
	wire logic       wrBit;
	wire logic       rdSlot;
	wire logic       rdBit;
	wire logic [7:0] featureByte;
	wire logic [7:0] controlByte;
	wire logic [1:0] wiperSelect;
	wire logic       pumpEnable;
	logic [7:0] rdVal;
	logic [7:0] badVals [5];
	int         fails;
	int         nTests;

	pfcr_regs u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .busReset(busReset), .cmdStart(cmdStart),
		.wrSlot(wrSlot), .wrBit(wrBit), .rdSlot(rdSlot), .rdBit(rdBit),
		.featureByte(featureByte), .controlByte(controlByte),
		.wiperSelect(wiperSelect), .pumpEnable(pumpEnable)
	);

	pfcr_master_model u_mst (
		.clk_sys(clk_sys), .busReset(busReset), .cmdStart(cmdStart),
		.wrSlot(wrSlot), .wrBit(wrBit), .rdSlot(rdSlot), .rdBit(rdBit)
	);

	// 50 ns period
	initial begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Byte comparison; narrower values are zero-extended by the caller
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8

	// Stored state as seen at the register view and pump output
	task automatic check_state(input logic [7:0] exp);
		@(negedge clk_sys);
		chk8("control", exp, controlByte);
		chk8("wiper select", {6'h00, exp[1:0]}, {6'h00, wiperSelect});
		chk8("pump enable", {7'h00, exp[6]}, {7'h00, pumpEnable});
	endtask : check_state

	// Register read: feature, control, then a zero fill byte
	task automatic rd_regs(input logic [7:0] expCtrl);
		u_mst.pulse_cmd(1'h0);
		u_mst.write_byte(8'hAA);
		u_mst.read_byte(rdVal);
		chk8("read feature", 8'hF3, rdVal);
		u_mst.read_byte(rdVal);
		chk8("read control", expCtrl, rdVal);
		u_mst.read_byte(rdVal);
		chk8("read fill", 8'h00, rdVal);
	endtask : rd_regs

	// Control write with echo and release handshake
	task automatic wr_ctrl(input logic [7:0] val, input logic [7:0] rel,
			input logic [7:0] expEcho, input logic [7:0] expTail);
		u_mst.pulse_cmd(1'h0);
		u_mst.write_byte(8'h55);
		u_mst.write_byte(val);
		u_mst.read_byte(rdVal);
		chk8("echo", expEcho, rdVal);
		u_mst.write_byte(rel);
		u_mst.read_byte(rdVal);
		chk8("tail", expTail, rdVal);
	endtask : wr_ctrl

	task automatic end_test(input string name);
		$display("test %s done, mismatches so far %0d", name, fails);
	endtask : end_test

	task automatic closeOut();
		$display("comparisons %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : closeOut

	// Hang guard
	initial begin
		repeat (30000) @(posedge clk_sys);
		fails++;
		closeOut();
	end

	// Main sequence
	initial begin
		rst_n = 1'h0;
		fails = 0;
		nTests = 0;
		badVals = '{8'h0D, 8'h09, 8'h1C, 8'h8C, 8'h00};
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'h1;
		check_state(8'h0C);
		chk8("feature", 8'hF3, featureByte);
		chk8("taper", 8'h01, {7'h00, featureByte[0]});
		chk8("volatility", 8'h01, {7'h00, featureByte[1]});
		chk8("count", 8'h00, {6'h00, featureByte[3:2]});
		chk8("positions", 8'h03, {6'h00, featureByte[5:4]});
		chk8("resistance", 8'h03, {6'h00, featureByte[7:6]});
		chk8("idle bit", 8'h01, {7'h00, rdBit});
		end_test("reset");
		rd_regs(8'h0C);
		end_test("read");
		wr_ctrl(8'h4C, 8'h96, 8'h4C, 8'h00);
		check_state(8'h4C);
		rd_regs(8'h4C);
		end_test("pump on");
		// Mismatched complement, other element, reserved bits, all zero
		for (int i = 0; i < 5; i++) begin
			wr_ctrl(badVals[i], 8'h96, 8'hFF, 8'hFF);
			check_state(8'h4C);
		end
		end_test("invalid");
		wr_ctrl(8'h0C, 8'h69, 8'h0C, 8'hFF);
		check_state(8'h4C);
		wr_ctrl(8'h0C, 8'h96, 8'h0C, 8'h00);
		check_state(8'h0C);
		end_test("release");
		u_mst.pulse_cmd(1'h0);
		u_mst.write_byte(8'h0F);
		u_mst.read_byte(rdVal);
		chk8("unknown cmd", 8'hFF, rdVal);
		u_mst.pulse_cmd(1'h0);
		u_mst.write_byte(8'h55);
		u_mst.write_byte(8'h4C);
		u_mst.read_byte(rdVal);
		chk8("echo", 8'h4C, rdVal);
		u_mst.pulse_cmd(1'h1);
		check_state(8'h0C);
		end_test("abort");
		wr_ctrl(8'h4C, 8'h96, 8'h4C, 8'h00);
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'h1;
		check_state(8'h0C);
		rd_regs(8'h0C);
		end_test("second reset");
		closeOut();
	end
endmodule : pfcr_regs_test
